// ==== include/uemr_params.svh ====
// constants for the usb endpoint mode responder
`ifndef UEMR_PARAMS_SVH
`define UEMR_PARAMS_SVH
`define UEMR_ADDR_EP0_MODE   4'h0
`define UEMR_ADDR_EP0_COUNT  4'h1
`define UEMR_ADDR_EP1_MODE   4'h2
`define UEMR_ADDR_EP1_COUNT  4'h3
`define UEMR_ADDR_STATUS     4'h4
`define UEMR_MODE_LSB        0
`define UEMR_MODE_MSB        3
`define UEMR_SETUP_BIT       7
`define UEMR_IN_BIT          6
`define UEMR_OUT_BIT         5
`define UEMR_ACK_BIT         4
`define UEMR_STALL_BIT       7
`define UEMR_MODE_RST        4'h0
`define UEMR_COUNT_RST       8'h00
`define UEMR_CRC_BYTES       5'h02
`define UEMR_LOCK_NS         1000
`define UEMR_CLK_NS          100
`define UEMR_LOCK_CYC        (`UEMR_LOCK_NS / `UEMR_CLK_NS)
`define UEMR_BUS_ERR         32'hDEADBEEF
`endif

// ==== include/uemr_pkg.sv ====
// types for the usb endpoint mode responder
package uemr_pkg;
	typedef enum logic [3:0] {
		MODE_DISABLE  = 4'b0000,
		MODE_NAK_IO   = 4'b0001,
		MODE_ST_OUT   = 4'b0010,
		MODE_STALL_IO = 4'b0011,
		MODE_IGN_IO   = 4'b0100,
		MODE_ISO_OUT  = 4'b0101,
		MODE_ST_IN    = 4'b0110,
		MODE_ISO_IN   = 4'b0111,
		MODE_NAK_OUT  = 4'b1000,
		MODE_ACK_OUT  = 4'b1001,
		MODE_NAK_OSI  = 4'b1010,
		MODE_ACK_OSI  = 4'b1011,
		MODE_NAK_IN   = 4'b1100,
		MODE_ACK_IN   = 4'b1101,
		MODE_NAK_ISO  = 4'b1110,
		MODE_ACK_ISO  = 4'b1111
	} uemr_mode_t;
	typedef enum logic [1:0] {
		TOK_NONE  = 2'b00,
		TOK_SETUP = 2'b01,
		TOK_IN    = 2'b10,
		TOK_OUT   = 2'b11
	} uemr_tok_t;
	typedef enum logic [2:0] {
		HS_NONE  = 3'b000,
		HS_ACK   = 3'b001,
		HS_NAK   = 3'b010,
		HS_STALL = 3'b011,
		HS_TX0   = 3'b100,
		HS_TXCNT = 3'b101
	} uemr_hs_t;
	// one finished transaction from the packet layer
	typedef struct packed {
		logic       valid;
		logic       ep;
		uemr_tok_t  tok;
		logic       addr_ok;
		logic       crc_ok;
		logic       err_ok;
		logic       data_toggle_bit;
		logic [5:0] count;
	} uemr_txn_t;
	typedef struct packed {
		logic       valid;
		logic       ep;
		uemr_hs_t   hs;
	} uemr_resp_t;
	typedef struct packed {
		logic [1:0][7:0] mode;
		logic [1:0][7:0] cnt;
		logic       [1:0] irq;
		logic             lock;
		logic       [3:0] lock_cnt;
		uemr_resp_t       resp;
		logic             waitreq;
		logic      [31:0] rdata;
		logic             done;
	} uemr_state_t;
endpackage : uemr_pkg

// ==== hw/uemr_responder.sv ====
// endpoint mode responder of the usb serial interface engine
`timescale 1ns/1ps
`include "uemr_params.svh"

// Contract
// - ack status out in 1111 gives 1110
// - endpoints reset disabled, stay until firmware
// - accepted setup forces mode 0001
// - setup accepting modes ack valid setup
// - control endpoint keeps setup, in, out bits
// - acked ack modes fall to nak mode, 1111 only on out
// - invalid transactions get no handshake
// - interrupt on valid completion or corruption
// - bad crc on out or setup corrupts
// - data valid if count within size plus two
// - out endpoint ignores in, vice versa
// - in and out bits set at end
// - setup bit set at data phase start
// - ack on endpoint 0 locks mode, count
// - only a cpu read releases the lock
// - writes blocked at least one microsecond
// - setup bit never write locked
// - mode code in low nibble of mode
// - check ack needs zero length, toggle one
// - ack in 1001 gives 1000
module uemr_responder import uemr_pkg::*; #(
	parameter int EP_SIZE  = 8,
	parameter int LOCK_CYC = `UEMR_LOCK_CYC
) (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	// avalon-mm slave
	input  wire logic  [3:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// packet layer
	input  wire logic        setup_data_start_i,
	input  wire logic        setup_ep_i,
	input  uemr_txn_t        txn_i,
	output uemr_resp_t       resp_o,
	output logic       [1:0] ep_irq_o
);
	uemr_state_t s_r;
	uemr_state_t s_nxt;

	function automatic logic setup_ok(input logic [3:0] m);
		setup_ok = (m != 4'h0) && (m != 4'h5) && (m != 4'h7) && (m[3:2] != 2'b10 || m[1])
			&& (m[3:2] != 2'b11 || m[1]);
	endfunction : setup_ok

	logic [3:0] md;
	logic       stl;
	logic       dok;
	logic       ack;
	logic       ev;
	uemr_hs_t   hs;
	logic [3:0] nm;

	always_comb begin
		s_nxt = s_r;
		s_nxt.resp.valid = 1'b0;
		md  = s_r.mode[txn_i.ep][3:0];
		stl = txn_i.ep & s_r.mode[txn_i.ep][`UEMR_STALL_BIT];
		// data packet: length bound, crc and error checks (address check not included)
		dok = txn_i.crc_ok && txn_i.err_ok
			&& (32'(txn_i.count) <= 32'(EP_SIZE) + 32'(`UEMR_CRC_BYTES));
		hs  = HS_NONE;
		nm  = md;
		ack = 1'b0;
		ev  = 1'b0;
		// setup flag rises when the data phase begins
		if (setup_data_start_i && setup_ok(s_r.mode[setup_ep_i][3:0]))
			s_nxt.mode[setup_ep_i][`UEMR_SETUP_BIT] = 1'b1;
		if (txn_i.valid) begin
			// disabled endpoints still report an empty reply
			s_nxt.resp.valid = 1'b1;
			s_nxt.resp.ep = txn_i.ep;
			s_nxt.resp.hs = HS_NONE;
		end
		if (txn_i.valid && md != MODE_DISABLE) begin
			case (txn_i.tok)
			TOK_SETUP: begin
				if (setup_ok(md) && dok) begin
					hs = HS_ACK;
					nm = MODE_NAK_IO;
					ev = 1'b1;
				end else if (setup_ok(md) && txn_i.addr_ok && !txn_i.crc_ok)
					ev = 1'b1;
			end
			TOK_IN: begin
				ev = 1'b1;
				case (md)
				MODE_NAK_IO, MODE_NAK_IN, MODE_NAK_ISO: hs = HS_NAK;
				MODE_ST_OUT, MODE_STALL_IO: hs = HS_STALL;
				MODE_ST_IN, MODE_NAK_OSI, MODE_ACK_OSI: hs = HS_TX0;
				MODE_ISO_IN: hs = HS_TXCNT;
				MODE_ACK_IN, MODE_ACK_ISO: hs = stl ? HS_STALL : HS_TXCNT;
				default: ev = 1'b0;
				endcase
				if (ev)
					s_nxt.mode[txn_i.ep][`UEMR_IN_BIT] = 1'b1;
			end
			TOK_OUT: begin
				ev = 1'b1;
				case (md)
				MODE_NAK_IO, MODE_NAK_OUT, MODE_NAK_OSI: hs = HS_NAK;
				MODE_STALL_IO, MODE_ST_IN: hs = HS_STALL;
				MODE_ISO_OUT: hs = HS_NONE;
				MODE_ACK_OUT, MODE_ACK_OSI: hs = stl ? HS_STALL : HS_ACK;
				MODE_ST_OUT, MODE_NAK_ISO, MODE_ACK_ISO:
					hs = (txn_i.count == 6'h02 && txn_i.data_toggle_bit) ? HS_ACK : HS_STALL;
				default: ev = 1'b0;
				endcase
				if (!dok) begin
					hs = HS_NONE;
					ev = ev && txn_i.addr_ok && !txn_i.crc_ok;
				end
				if (ev && dok)
					s_nxt.mode[txn_i.ep][`UEMR_OUT_BIT] = 1'b1;
			end
			default: ev = 1'b0;
			endcase
			if (hs == HS_ACK || (hs == HS_TXCNT && txn_i.tok == TOK_IN)) begin
				ack = 1'b1;
				case (md)
				MODE_ACK_OUT: nm = MODE_NAK_OUT;
				MODE_ACK_OSI: nm = MODE_NAK_OSI;
				MODE_ACK_IN: nm = MODE_NAK_IN;
				MODE_ACK_ISO: nm = (txn_i.tok == TOK_OUT) ? MODE_NAK_ISO : MODE_ACK_ISO;
				default: ;
				endcase
				if (txn_i.tok == TOK_SETUP)
					nm = MODE_NAK_IO;
			end
			s_nxt.mode[txn_i.ep][3:0] = nm;
			s_nxt.mode[txn_i.ep][`UEMR_ACK_BIT] = ack;
			if (ev && (dok || txn_i.tok == TOK_IN))
				s_nxt.cnt[txn_i.ep] = {2'b00, txn_i.count};
			s_nxt.irq[txn_i.ep] = s_r.irq[txn_i.ep] | ev;
			s_nxt.resp.hs = hs;
			// acked endpoint 0 transfer freezes its registers
			if (ack && !txn_i.ep) begin
				s_nxt.lock = 1'b1;
				s_nxt.lock_cnt = 4'(LOCK_CYC);
			end
		end
		if (s_r.lock_cnt != 4'h0)
			s_nxt.lock_cnt = s_r.lock_cnt - 4'h1;
		// bus slave: one wait state, side effects land on the answer edge
		s_nxt.done = 1'b0;
		s_nxt.waitreq = 1'b1;
		if ((avs_read_i || avs_write_i) && s_r.waitreq && !s_r.done) begin
			s_nxt.waitreq = 1'b0;
			s_nxt.done = 1'b1;
			s_nxt.rdata = 32'h0;
			if (avs_read_i) begin
				if (avs_address_i == `UEMR_ADDR_EP0_MODE)
					s_nxt.rdata = {24'h0, s_r.mode[0]};
				else if (avs_address_i == `UEMR_ADDR_EP0_COUNT)
					s_nxt.rdata = {24'h0, s_r.cnt[0]};
				else if (avs_address_i == `UEMR_ADDR_EP1_MODE)
					s_nxt.rdata = {24'h0, s_r.mode[1]};
				else if (avs_address_i == `UEMR_ADDR_EP1_COUNT)
					s_nxt.rdata = {24'h0, s_r.cnt[1]};
				else if (avs_address_i == `UEMR_ADDR_STATUS)
					s_nxt.rdata = {29'h0, s_r.lock, s_r.irq};
				else
					s_nxt.rdata = `UEMR_BUS_ERR;
			end
		end
		if (!s_r.waitreq) begin
			if (avs_read_i) begin
				// read after the lock window opens the registers; a new lock wins
				if (s_r.lock_cnt == 4'h0 && !(ack && !txn_i.ep) && (avs_address_i == `UEMR_ADDR_EP0_MODE
					|| avs_address_i == `UEMR_ADDR_EP0_COUNT))
					s_nxt.lock = 1'b0;
			end else if (avs_write_i) begin
				if (avs_address_i == `UEMR_ADDR_EP0_MODE) begin
					if (!s_r.lock) begin
						s_nxt.mode[0][6:0] = avs_writedata_i[6:0];
					end
					// setup flag stays writable while locked; hardware set wins
					if (!(setup_data_start_i && !setup_ep_i))
						s_nxt.mode[0][`UEMR_SETUP_BIT] = avs_writedata_i[`UEMR_SETUP_BIT];
				end else if (avs_address_i == `UEMR_ADDR_EP0_COUNT) begin
					if (!s_r.lock)
						s_nxt.cnt[0] = avs_writedata_i[7:0];
				end else if (avs_address_i == `UEMR_ADDR_EP1_MODE)
					s_nxt.mode[1] = avs_writedata_i[7:0];
				else if (avs_address_i == `UEMR_ADDR_EP1_COUNT)
					s_nxt.cnt[1] = avs_writedata_i[7:0];
				else if (avs_address_i == `UEMR_ADDR_STATUS)
					s_nxt.irq = (s_r.irq & ~avs_writedata_i[1:0]) | {ev & txn_i.ep, ev & !txn_i.ep};
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
			s_r.waitreq <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign avs_readdata_o    = s_r.rdata;
	assign avs_waitrequest_o = s_r.waitreq;
	assign resp_o            = s_r.resp;
	assign ep_irq_o          = s_r.irq;
endmodule : uemr_responder

// ==== verification/uemr_asserts.sv ====
// checker for the endpoint responder
`timescale 1ns/1ps
module uemr_asserts import uemr_pkg::*; #(parameter int EP_SIZE = 8) (
	input wire logic       ref_clk_i,
	input wire logic       sys_rst_i,
	input wire logic       avs_read_i,
	input wire logic       avs_write_i,
	input wire logic       avs_waitrequest_o,
	input uemr_txn_t       txn_i,
	input uemr_resp_t      resp_o,
	input wire logic [1:0] ep_irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_ws; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
	a_ws: assert property (p_ws) else $error("no bus answer");
	property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
	a_one: assert property (p_one) else $error("answer too long");
	// data checks only apply to tokens that carry a data packet
	property p_bad;
		txn_i.valid && txn_i.tok != TOK_IN && !(txn_i.crc_ok && txn_i.err_ok) |=> resp_o.hs == HS_NONE;
	endproperty
	a_bad: assert property (p_bad) else $error("bad packet answered");
	property p_long;
		txn_i.valid && txn_i.tok != TOK_IN && txn_i.count > EP_SIZE + 2 |=> resp_o.hs == HS_NONE;
	endproperty
	a_long: assert property (p_long) else $error("long packet answered");
	property p_src; resp_o.valid |-> $past(txn_i.valid); endproperty
	a_src: assert property (p_src) else $error("reply without packet");
	property p_irq; resp_o.valid && resp_o.hs != HS_NONE |-> ep_irq_o[resp_o.ep]; endproperty
	a_irq: assert property (p_irq) else $error("missing interrupt");
	property p_rise; $rose(ep_irq_o[0]) |-> resp_o.valid && !resp_o.ep; endproperty
	a_rise: assert property (p_rise) else $error("stray interrupt");
	property p_rst; $fell(sys_rst_i) |-> ep_irq_o == 2'h0 && !resp_o.valid; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	c_ack: cover property (resp_o.valid && resp_o.hs == HS_ACK);
	c_nak: cover property (resp_o.valid && resp_o.hs == HS_NAK);
	c_none: cover property (resp_o.valid && resp_o.hs == HS_NONE);
endmodule : uemr_asserts
bind uemr_responder uemr_asserts #(.EP_SIZE(EP_SIZE)) i_uemr_asserts (.ref_clk_i, .sys_rst_i, .avs_read_i,
	.avs_write_i, .avs_waitrequest_o, .txn_i, .resp_o, .ep_irq_o);

// ==== verification/uemr_host.sv ====
// host token source model
`timescale 1ns/1ps
module uemr_host import uemr_pkg::*; (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic go_i,
	input  uemr_txn_t req_i,
	output uemr_txn_t txn_o,
	output logic      sds_o
);
	uemr_txn_t q;
	always_ff @(posedge clk_i) begin
		q <= req_i;
		// setup data phase starts a cycle before the end
		sds_o <= !rst_i && go_i && req_i.tok == TOK_SETUP;
		if (rst_i)
			txn_o <= '0;
		else if (sds_o)
			txn_o <= q;
		else if (go_i && req_i.tok != TOK_SETUP)
			txn_o <= req_i;
		else
			txn_o <= uemr_txn_t'({1'b0, ~txn_o[12:0]});
	end
endmodule : uemr_host

// ==== verification/testbench.sv ====
// self-checking bench for the endpoint responder
`timescale 1ns/1ps
module testbench import uemr_pkg::*;;
	localparam int EPS = 8;
	logic ref_clk_i = '0, sys_rst_i = '1, avs_read_i = '0, avs_write_i = '0, go = '0, sds, wq;
	logic [3:0]  avs_address_i = 4'h0;
	logic [31:0] avs_writedata_i = 32'h0, rd, rdata;
	logic [1:0]  irq;
	logic [16:0] lf = 17'h17954;
	logic [5:0]  c;
	uemr_txn_t   req = '0, txn;
	uemr_resp_t  resp;
	int          err_total = 0, cmp_count = 0;
	always #50 ref_clk_i = ~ref_clk_i;
	uemr_responder #(.EP_SIZE(EPS), .LOCK_CYC(2)) i_uemr_responder (.ref_clk_i, .sys_rst_i, .avs_address_i,
		.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o(rd), .avs_waitrequest_o(wq),
		.setup_data_start_i(sds), .setup_ep_i(req.ep), .txn_i(txn), .resp_o(resp), .ep_irq_o(irq));
	uemr_host i_uemr_host (.clk_i(ref_clk_i), .rst_i(sys_rst_i), .go_i(go), .req_i(req), .txn_o(txn), .sds_o(sds));
	function automatic logic [16:0] nxt(logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : nxt
	function automatic logic f_ok(logic [5:0] n);
		return n <= EPS + 2;
	endfunction : f_ok
	task automatic ck(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : ck
	task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
		@(posedge ref_clk_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		// the watchdog bounds this wait
		do @(posedge ref_clk_i); while (wq !== 1'b0);
		rdata = rd;
		avs_write_i <= '0;
		avs_read_i <= '0;
	endtask : bus
	task automatic rm(logic [3:0] a, logic [3:0] e);
		bus('0, a, 32'h0);
		ck("mode", e, rdata[3:0]);
	endtask : rm
	task automatic tk(logic e, uemr_tok_t t, logic [5:0] n, logic g, uemr_hs_t x);
		@(posedge ref_clk_i);
		req <= {1'b1, e, t, 1'b1, g, 2'h3, n};
		go <= '1;
		@(posedge ref_clk_i);
		go <= '0;
		repeat (1 + (t == TOK_SETUP)) @(posedge ref_clk_i);
		#1 ck("hs", x, resp.hs);
		// lets the lock window run out
		repeat (4) @(posedge ref_clk_i);
	endtask : tk
	task automatic end_sim();
		$display("checks %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	initial begin
		#400000;
		err_total++;
		end_sim();
	end
	initial begin
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= '0;
		rm(4'h0, 4'h0);
		tk('0, TOK_SETUP, 6'h02, '1, HS_NONE);
		ck("irq", 32'h0, irq);
		bus('1, 4'h0, 32'h0F);
		tk('0, TOK_OUT, 6'h02, '1, HS_ACK);
		bus('1, 4'h0, 32'h0B);
		rm(4'h0, 4'hE);
		ck("out", 32'h1, rdata[5]);
		ck("irq", 32'h1, irq[0]);
		bus('1, 4'h0, 32'h0B);
		tk('0, TOK_OUT, 6'h02, '1, HS_ACK);
		rm(4'h0, 4'hA);
		tk('0, TOK_OUT, 6'h02, '1, HS_NAK);
		tk('0, TOK_SETUP, 6'h0A, '1, HS_ACK);
		rm(4'h0, 4'h1);
		ck("setup", 32'h1, rdata[7]);
		tk('0, TOK_OUT, 6'h02, '0, HS_NONE);
		tk('0, TOK_OUT, 6'h0B, '1, HS_NONE);
		rm(4'h0, 4'h1);
		bus('1, 4'h0, 32'h03);
		tk('0, TOK_IN, 6'h02, '1, HS_STALL);
		rm(4'h0, 4'h3);
		ck("in", 32'h1, rdata[6]);
		bus('1, 4'h2, 32'h9);
		tk('1, TOK_IN, 6'h02, '1, HS_NONE);
		bus('1, 4'h2, 32'hD);
		tk('1, TOK_IN, 6'h04, '1, HS_TXCNT);
		rm(4'h2, 4'hC);
		tk('1, TOK_IN, 6'h04, '1, HS_NAK);
		repeat (4) begin
			lf = nxt(lf);
			c = 6'h02 + lf[3:0];
			bus('1, 4'h2, 32'h9);
			tk('1, TOK_OUT, c, '1, f_ok(c) ? HS_ACK : HS_NONE);
			rm(4'h2, f_ok(c) ? 4'h8 : 4'h9);
		end
		bus('1, 4'h4, 32'h3);
		@(posedge ref_clk_i);
		ck("irq", 32'h0, irq);
		bus('0, 4'h4, 32'h0);
		ck("status", 32'h0, rdata[1:0]);
		end_sim();
	end
endmodule : testbench
